// File: bsram_pkg.sv
// Constants, field layouts and types of the dual-port block memory
// Assumes one system clock; port clocks arrive as slow inputs on it
//
// Functional notes
// - Writes are taken into input registers on the port clock; output register optional
// - Dual mode: both ports work independently, own clock and write enable
// - Single mode: exactly one read or write on port A per active edge
// - Single mode supports normal and write-through behaviour
// - Single mode bypassed: written data shows at the writing edge
// - Single shapes 16384x1 up to 512x32, plus 2048x9, 1024x18, 512x36
// - Dual mode: two reads, two writes, or read plus write, any clock rates
// - Dual shapes 16384x1 to 1024x16, 2048x9, 1024x18; no 32 or 36 wide
// - Semi-dual: port A only writes, port B only reads, concurrently
// - Semi-dual offers every single-port shape including 512x36
// - Contents filled with INIT_WORD during power-on; image words loaded over APB once ready
// - Read-only mode presents the same 16 kbit shapes and ninth-bit shapes
// - Read-only: register reset clears port registers, never stored contents
// - Pipeline read: read data flows through output and pipeline registers, 36 bits
// - Bypass read: data taken from held array output, no output register
// - Normal write leaves the port's read output unchanged
// - Write-through drives the written data onto the port's output
// - Read-before-write outputs the old value at the written address
// - Clocking scheme follows the mode: independent, write/read, single
// - Independent clocking: each port clock drives all its port registers
// - Write/read clocking: A clock takes write side, B clock the read side
// - Each port has an input clock enable and an output clock enable
// - Read and write widths may differ; ninth-bit widths only pair together
// - Masked bytes of a wide word are not written and keep contents
// - During power-up the block stands by with both port read outputs zero
package bsram_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 36;
  localparam int WORDS  = 512;
  localparam int WORD_AW = 9;
  localparam int APB_AW = 8;
  localparam int CFG_W  = 14;

  localparam logic [7:0] CFG_OFS      = 8'h00;
  localparam logic [7:0] STAT_OFS     = 8'h04;
  localparam logic [7:0] IMG_ADDR_OFS = 8'h08;
  localparam logic [7:0] IMG_LO_OFS   = 8'h0C;
  localparam logic [7:0] IMG_HI_OFS   = 8'h10;

  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_PIPE_BIT  = 2;
  localparam int CFG_WMODE_LSB = 3;
  localparam int CFG_SRST_BIT  = 5;
  localparam int CFG_WA_LSB    = 6;
  localparam int CFG_WB_LSB    = 10;
  localparam logic [CFG_W-1:0] CFG_RESET = 14'h0CC0;

  localparam int STAT_READY_BIT = 0;
  localparam int STAT_SHAPE_BIT = 1;
  localparam int IMG_HI_W = 4;

  // Width codes: 0..5 give 1..32 bits, 6..8 give 9, 18, 36 bits
  localparam logic [3:0] NINE_FIRST = 4'h6;
  localparam logic [3:0] CODE_LAST  = 4'h8;
  localparam logic [3:0] CODE_W16   = 4'h4;
  localparam logic [3:0] CODE_W32   = 4'h5;
  localparam logic [3:0] CODE_W18   = 4'h7;
  localparam logic [3:0] CODE_W36   = 4'h8;
  localparam logic [3:0] VIEW8_LOG  = 4'h5;
  localparam logic [3:0] VIEW9_LOG  = 4'h2;
  localparam logic [5:0] LANE9      = 6'h09;
  localparam int LANES = 4;

  typedef enum logic [1:0] {MODE_SINGLE, MODE_DUAL, MODE_SEMI, MODE_ROM} mode_t;
  typedef enum logic [1:0] {WR_NORMAL, WR_THROUGH, WR_RBW, WR_SPARE} wmode_t;
  typedef enum logic {ST_STANDBY, ST_RUN} pstate_t;
endpackage

// File: bsram_block.sv
// Two-port block memory with APB configuration and image loading
// Port clocks are sampled inputs, far slower than SYS_CLK
`timescale 1ns/1ps
module bsram_block #(
  parameter logic [35:0] INIT_WORD = 36'h000000000
)(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        BLOCK_SELECT,
  input  wire logic        PORT_A_CLOCK,
  input  wire logic        PORT_A_INPUT_CLOCK_ENABLE,
  input  wire logic        PORT_A_OUTPUT_CLOCK_ENABLE,
  input  wire logic        PORT_A_WRITE_ENABLE,
  input  wire logic        PORT_A_REGISTER_RESET,
  input  wire logic [13:0] PORT_A_LOCATION,
  input  wire logic [35:0] PORT_A_WRITE_DATA,
  input  wire logic [3:0]  PORT_A_BYTE_ENABLE,
  output logic      [35:0] PORT_A_READ_DATA,
  input  wire logic        PORT_B_CLOCK,
  input  wire logic        PORT_B_INPUT_CLOCK_ENABLE,
  input  wire logic        PORT_B_OUTPUT_CLOCK_ENABLE,
  input  wire logic        PORT_B_WRITE_ENABLE,
  input  wire logic        PORT_B_REGISTER_RESET,
  input  wire logic [13:0] PORT_B_LOCATION,
  input  wire logic [35:0] PORT_B_WRITE_DATA,
  input  wire logic [3:0]  PORT_B_BYTE_ENABLE,
  output logic      [35:0] PORT_B_READ_DATA
);

  // Geometry helpers
  function automatic logic [4:0] elem_ix(input logic [3:0] c, input logic [13:0] a);
    logic [3:0] k;
    k = c - bsram_pkg::NINE_FIRST;
    if (c < bsram_pkg::NINE_FIRST) begin
      elem_ix = 5'(a & ((14'h0001 << (bsram_pkg::VIEW8_LOG - c)) - 14'h0001));
    end else begin
      elem_ix = 5'(a & ((14'h0001 << (bsram_pkg::VIEW9_LOG - k)) - 14'h0001));
    end
  endfunction

  function automatic logic [8:0] word_ix(input logic [3:0] c, input logic [13:0] a);
    logic [3:0] k;
    k = c - bsram_pkg::NINE_FIRST;
    if (c < bsram_pkg::NINE_FIRST) begin
      word_ix = 9'(a >> (bsram_pkg::VIEW8_LOG - c));
    end else begin
      word_ix = 9'(a >> (bsram_pkg::VIEW9_LOG - k));
    end
  endfunction

  function automatic logic [5:0] elem_w(input logic [3:0] c);
    logic [3:0] k;
    k = c - bsram_pkg::NINE_FIRST;
    if (c < bsram_pkg::NINE_FIRST) begin
      elem_w = 6'h01 << c;
    end else begin
      elem_w = bsram_pkg::LANE9 << k;
    end
  endfunction

  function automatic logic [3:0] lane_sel(input logic [3:0] c, input logic [3:0] be,
                                          input logic [4:0] e);
    if (c == bsram_pkg::CODE_W16 || c == bsram_pkg::CODE_W18) begin
      lane_sel = 4'((be & 4'h3) << {e[0], 1'h0});
    end else if (c == bsram_pkg::CODE_W32 || c == bsram_pkg::CODE_W36) begin
      lane_sel = be;
    end else begin
      lane_sel = 4'hF;
    end
  endfunction

  function automatic logic [35:0] lane_mask(input logic [3:0] l, input logic nine);
    lane_mask = 36'h000000000;
    for (int i = 0; i < bsram_pkg::LANES; i++) begin
      if (nine) begin
        lane_mask[i*9 +: 9] = {9{l[i]}};
      end else begin
        lane_mask[i*8 +: 8] = {8{l[i]}};
      end
    end
  endfunction

  function automatic logic [35:0] to_view(input logic [35:0] w, input logic nine);
    to_view = nine ? w : {4'h0, w[34:27], w[25:18], w[16:9], w[7:0]};
  endfunction

  function automatic logic [35:0] from_view(input logic [35:0] v, input logic [35:0] w,
                                            input logic nine);
    from_view = nine ? v : {w[35], v[31:24], w[26], v[23:16], w[17], v[15:8], w[8], v[7:0]};
  endfunction

  function automatic logic code_ok(input logic [3:0] c);
    code_ok = c <= bsram_pkg::CODE_LAST;
  endfunction

  // Power-up standby and INIT_WORD fill
  bsram_pkg::pstate_t       state_r;
  bsram_pkg::pstate_t       state_nxt;
  logic [8:0]               init_cnt_r;
  logic [8:0]               init_cnt_nxt;
  logic                     ready;

  // APB registers
  logic                     pready_r;
  logic [31:0]              prdata_r;
  logic                     pslverr_r;
  logic [bsram_pkg::CFG_W-1:0] cfg_r;
  logic [8:0]               img_addr_r;
  logic [3:0]               img_hi_r;

  // Memory array and port state
  logic [35:0]              mem_r [bsram_pkg::WORDS];
  logic [1:0]               pclk_q_r;
  logic [35:0]              lat_r [2];
  logic [35:0]              pipe_r [2];
  logic [35:0]              out_r [2];

  wire logic [1:0]  pclk  = {PORT_B_CLOCK, PORT_A_CLOCK};
  wire logic [1:0]  ice   = {PORT_B_INPUT_CLOCK_ENABLE, PORT_A_INPUT_CLOCK_ENABLE};
  wire logic [1:0]  oce   = {PORT_B_OUTPUT_CLOCK_ENABLE, PORT_A_OUTPUT_CLOCK_ENABLE};
  wire logic [1:0]  we    = {PORT_B_WRITE_ENABLE, PORT_A_WRITE_ENABLE};
  wire logic [1:0]  rrst  = {PORT_B_REGISTER_RESET, PORT_A_REGISTER_RESET};
  wire logic [13:0] loc  [2];
  wire logic [35:0] wdat [2];
  wire logic [3:0]  ben  [2];
  assign loc[0]  = PORT_A_LOCATION;
  assign loc[1]  = PORT_B_LOCATION;
  assign wdat[0] = PORT_A_WRITE_DATA;
  assign wdat[1] = PORT_B_WRITE_DATA;
  assign ben[0]  = PORT_A_BYTE_ENABLE;
  assign ben[1]  = PORT_B_BYTE_ENABLE;

  // Configuration decode
  wire bsram_pkg::mode_t  mode  = bsram_pkg::mode_t'(cfg_r[bsram_pkg::CFG_MODE_LSB +: 2]);
  wire bsram_pkg::wmode_t wmode = bsram_pkg::wmode_t'(cfg_r[bsram_pkg::CFG_WMODE_LSB +: 2]);
  wire logic       pipe_on  = cfg_r[bsram_pkg::CFG_PIPE_BIT];
  wire logic       sync_rst = cfg_r[bsram_pkg::CFG_SRST_BIT];
  wire logic [3:0] code_a   = cfg_r[bsram_pkg::CFG_WA_LSB +: 4];
  wire logic [3:0] code_b   = cfg_r[bsram_pkg::CFG_WB_LSB +: 4];
  wire logic       nine_a   = code_a >= bsram_pkg::NINE_FIRST;
  wire logic       nine_b   = code_b >= bsram_pkg::NINE_FIRST;
  wire logic       wide_any = code_a == bsram_pkg::CODE_W32 || code_a == bsram_pkg::CODE_W36 ||
                              code_b == bsram_pkg::CODE_W32 || code_b == bsram_pkg::CODE_W36;
  wire logic       one_port = mode == bsram_pkg::MODE_SINGLE || mode == bsram_pkg::MODE_ROM;
  wire logic       shape_ok = code_ok(code_a) &&
                              (one_port || (code_ok(code_b) && nine_a == nine_b &&
                               (mode != bsram_pkg::MODE_DUAL || !wide_any)));

  assign ready = state_r == bsram_pkg::ST_RUN;

  // APB decode
  wire logic ap_req  = PSEL & PENABLE & ~pready_r;
  wire logic ap_done = PSEL & PENABLE & pready_r;
  wire logic ap_wr   = ap_done & PWRITE;
  wire logic sel_cfg = PADDR == bsram_pkg::CFG_OFS;
  wire logic sel_st  = PADDR == bsram_pkg::STAT_OFS;
  wire logic sel_ia  = PADDR == bsram_pkg::IMG_ADDR_OFS;
  wire logic sel_lo  = PADDR == bsram_pkg::IMG_LO_OFS;
  wire logic sel_hi  = PADDR == bsram_pkg::IMG_HI_OFS;
  wire logic mapped  = sel_cfg | sel_st | sel_ia | sel_lo | sel_hi;
  wire logic img_put = ap_wr & sel_lo & ready;
  wire logic [31:0] stat_word = {30'h00000000, ~shape_ok, ready};
  wire logic [31:0] rd_mux = sel_cfg ? 32'(cfg_r) :
                             sel_st  ? stat_word :
                             sel_ia  ? 32'(img_addr_r) :
                             sel_hi  ? 32'(img_hi_r) : 32'h00000000;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pready_r   <= 1'h0;
      prdata_r   <= 32'h00000000;
      pslverr_r  <= 1'h0;
      cfg_r      <= bsram_pkg::CFG_RESET;
      img_addr_r <= 9'h000;
      img_hi_r   <= 4'h0;
    end else begin
      pready_r   <= ap_req;
      prdata_r   <= (ap_req && !PWRITE) ? rd_mux : 32'h00000000;
      pslverr_r  <= ap_req & ~mapped;
      cfg_r      <= (ap_wr && sel_cfg) ? PWDATA[bsram_pkg::CFG_W-1:0] : cfg_r;
      img_addr_r <= (ap_wr && sel_ia) ? PWDATA[8:0] : img_addr_r + 9'(img_put);
      img_hi_r   <= (ap_wr && sel_hi) ? PWDATA[3:0] : img_hi_r;
    end
  end

  // Power-up fill walks every word before the ports open
  assign state_nxt    = (init_cnt_r == 9'(bsram_pkg::WORDS - 1)) ? bsram_pkg::ST_RUN : state_r;
  assign init_cnt_nxt = ready ? init_cnt_r : init_cnt_r + 9'h001;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r    <= bsram_pkg::ST_STANDBY;
      init_cnt_r <= 9'h000;
      pclk_q_r   <= 2'h0;
    end else begin
      state_r    <= state_nxt;
      init_cnt_r <= init_cnt_nxt;
      pclk_q_r   <= pclk;
    end
  end

  // Per-port access logic
  logic [1:0]  pedge;
  logic [1:0]  acc;
  logic [1:0]  wr;
  logic [1:0]  rd;
  logic [1:0]  rst_now;
  logic [8:0]  word [2];
  logic [35:0] wmask [2];
  logic [35:0] rd_elem [2];
  logic [35:0] new_word [2];
  logic [35:0] lat_nxt [2];
  logic [35:0] pipe_nxt [2];
  logic [35:0] out_nxt [2];

  for (genvar g = 0; g < 2; g++) begin : g_port
    wire logic [3:0]  code  = g ? code_b : code_a;
    wire logic        nine  = code >= bsram_pkg::NINE_FIRST;
    wire logic [4:0]  e     = elem_ix(code, loc[g]);
    wire logic [5:0]  w     = elem_w(code);
    wire logic [5:0]  off   = 6'(e * w);
    wire logic [35:0] wm    = 36'((37'h000000001 << w) - 37'h000000001);
    wire logic [35:0] m     = (wm << off) & lane_mask(lane_sel(code, ben[g], e), nine);
    wire logic [35:0] old_w = mem_r[word[g]];
    wire logic [35:0] base  = (g == 1 && wr[0] && word[0] == word[1]) ? new_word[0] : old_w;
    wire logic [35:0] v_b   = to_view(base, nine);
    wire logic        on    = !one_port || g == 0;
    wire logic        wr_ok = mode == bsram_pkg::MODE_DUAL || mode == bsram_pkg::MODE_SINGLE ||
                              (mode == bsram_pkg::MODE_SEMI && g == 0);
    wire logic        rd_ok = mode != bsram_pkg::MODE_SEMI || g == 1;

    assign pedge[g]    = pclk[g] & ~pclk_q_r[g];
    assign acc[g]      = pedge[g] & ice[g] & BLOCK_SELECT & ready & shape_ok & on;
    assign wr[g]       = acc[g] & we[g] & wr_ok;
    assign rd[g]       = acc[g] & ~we[g] & rd_ok;
    assign word[g]     = word_ix(code, loc[g]);
    assign wmask[g]    = wm;
    assign rd_elem[g]  = (to_view(old_w, nine) >> off) & wm;
    assign new_word[g] = from_view((v_b & ~m) | ((wdat[g] << off) & m), base, nine);
    assign rst_now[g]  = rrst[g] & (~sync_rst | pedge[g]);

    always_comb begin
      lat_nxt[g] = lat_r[g];
      if (rst_now[g]) begin
        lat_nxt[g] = 36'h000000000;
      end else if (rd[g]) begin
        lat_nxt[g] = rd_elem[g];
      end else if (wr[g] && wmode == bsram_pkg::WR_THROUGH) begin
        lat_nxt[g] = wdat[g] & wm;
      end else if (wr[g] && wmode == bsram_pkg::WR_RBW) begin
        lat_nxt[g] = rd_elem[g];
      end
    end

    assign pipe_nxt[g] = rst_now[g] ? 36'h000000000 :
                         (pedge[g] && oce[g] && ready) ? lat_r[g] : pipe_r[g];
    assign out_nxt[g]  = !ready ? 36'h000000000 :
                         pipe_on ? pipe_nxt[g] : lat_nxt[g];

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
        lat_r[g]  <= 36'h000000000;
        pipe_r[g] <= 36'h000000000;
        out_r[g]  <= 36'h000000000;
      end else begin
        lat_r[g]  <= lat_nxt[g];
        pipe_r[g] <= pipe_nxt[g];
        out_r[g]  <= out_nxt[g];
      end
    end
  end

  // Array writes: fill, image load, then the ports
  always_ff @(posedge SYS_CLK) begin
    if (!ready) begin
      mem_r[init_cnt_r] <= INIT_WORD;
    end else if (img_put) begin
      mem_r[img_addr_r] <= {img_hi_r, PWDATA};
    end
    for (int p = 0; p < 2; p++) begin
      if (wr[p]) begin
        mem_r[word[p]] <= new_word[p];
      end
    end
  end

  assign PRDATA           = prdata_r;
  assign PREADY           = pready_r;
  assign PSLVERR          = pslverr_r;
  assign PORT_A_READ_DATA = out_r[0];
  assign PORT_B_READ_DATA = out_r[1];

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  a_standby_outputs: assert property (!ready |=> out_r[0] == 36'h0 && out_r[1] == 36'h0)
    else $error("Output not zero during standby");
  a_bypass_read: assert property (rd[0] && !rrst[0] && !pipe_on |=>
      out_r[0] == $past(rd_elem[0]))
    else $error("Bypass read data wrong");
  a_write_through: assert property (wr[0] && !rrst[0] && !pipe_on &&
      wmode == bsram_pkg::WR_THROUGH |=> PORT_A_READ_DATA == $past(wdat[0] & wmask[0]))
    else $error("Write-through data missing");
  a_normal_hold: assert property (wr[0] && !rrst[0] && wmode == bsram_pkg::WR_NORMAL |=>
      lat_r[0] == $past(lat_r[0]))
    else $error("Normal write changed output");
  a_rbw_old: assert property (wr[0] && !rrst[0] && wmode == bsram_pkg::WR_RBW |=>
      lat_r[0] == $past(rd_elem[0]))
    else $error("Read-before-write lost old value");
  a_reg_reset: assert property (rrst[0] && !sync_rst ##1 rrst[0] |->
      lat_r[0] == 36'h0 && pipe_r[0] == 36'h0)
    else $error("Register reset did not clear");
  a_semi_roles: assert property (mode == bsram_pkg::MODE_SEMI |-> !wr[1] && !rd[0])
    else $error("Semi-dual port role broken");
  a_single_b_idle: assert property (one_port |-> !acc[1])
    else $error("Port B active in one-port mode");
  a_mem_store: assert property (wr[0] && !wr[1] |=> mem_r[$past(word[0])] ==
      $past(new_word[0]))
    else $error("Write not stored");
  a_apb_wait: assert property (ap_req |=> PREADY ##1 !PREADY)
    else $error("APB answer timing wrong");

  // Pipeline, enable, read-only, port B, image and power-up checks
  a_pipe_load: assert property (pedge[0] && oce[0] && ready && !rrst[0] |=>
      pipe_r[0] == $past(lat_r[0]))
    else $error("Pipeline register missed load");
  a_pipe_out: assert property (pipe_on && pedge[0] && oce[0] && ready && !rrst[0] |=>
      out_r[0] == $past(lat_r[0]))
    else $error("Pipelined read data wrong");
  a_pipe_hold: assert property (!oce[0] && !rrst[0] |=> pipe_r[0] == $past(pipe_r[0]))
    else $error("Pipeline moved without enable");
  a_input_gate: assert property (!ice[0] && !rrst[0] |=> lat_r[0] == $past(lat_r[0]))
    else $error("Access taken without enable");
  a_rom_keep: assert property (mode == bsram_pkg::MODE_ROM && ready && !img_put |=>
      mem_r[$past(word[0])] == $past(mem_r[word[0]]))
    else $error("Read-only contents changed");
  a_b_store: assert property (wr[1] |=> mem_r[$past(word[1])] == $past(new_word[1]))
    else $error("Port B write not stored");
  a_b_bypass: assert property (rd[1] && !rrst[1] && !pipe_on |=>
      out_r[1] == $past(rd_elem[1]))
    else $error("Port B read data wrong");
  a_b_normal: assert property (wr[1] && !rrst[1] && wmode == bsram_pkg::WR_NORMAL |=>
      lat_r[1] == $past(lat_r[1]))
    else $error("Port B normal write changed output");
  a_b_quiet: assert property (one_port && !rrst[1] |=> lat_r[1] == $past(lat_r[1]))
    else $error("Port B latch moved in one-port mode");
  a_b_reset: assert property (rrst[1] && !sync_rst ##1 rrst[1] |->
      lat_r[1] == 36'h0 && out_r[1] == 36'h0)
    else $error("Port B register reset did not clear");
  a_image_load: assert property (img_put && !wr[0] && !wr[1] |=>
      mem_r[$past(img_addr_r)] == {$past(img_hi_r), $past(PWDATA)})
    else $error("Image word not stored");
  a_addr_step: assert property (img_put |=> img_addr_r == $past(img_addr_r) + 9'h001)
    else $error("Image address did not advance");
  a_fill_step: assert property (!ready |=> init_cnt_r == $past(init_cnt_r) + 9'h001)
    else $error("Power-up fill stalled");
  a_ready_hold: assert property (ready |=> ready)
    else $error("Block left run state");
  a_standby_pipe: assert property (!ready |=> pipe_r[0] == 36'h0 && pipe_r[1] == 36'h0)
    else $error("Pipeline not zero during standby");

  c_dual_writes: cover property (wr[0] && wr[1]);
  c_pipe_read: cover property (pipe_on && rd[0] ##[1:40] pedge[0] && oce[0]);
  c_rbw: cover property (wr[0] && wmode == bsram_pkg::WR_RBW);
  c_semi_flow: cover property (mode == bsram_pkg::MODE_SEMI && wr[0] && rd[1]);
  c_image_load: cover property (img_put);
endmodule

// File: bsram_user.sv
// Fabric-side user logic model driving one port of the block memory
// Assumes a free-running system clock; the port clock idles low between accesses
`timescale 1ns/1ps
module bsram_user #(
  parameter int GAP = 0
)(
  input  wire logic        sys_clk,
  output logic             pclk,
  output logic             in_en,
  output logic             out_en,
  output logic             wr_en,
  output logic             reg_rst,
  output logic      [13:0] loc,
  output logic      [35:0] wdata,
  output logic      [3:0]  be
);
  initial begin
    pclk = 1'b0;
    in_en = 1'b0;
    out_en = 1'b1;
    wr_en = 1'b0;
    reg_rst = 1'b0;
    loc = 14'h0000;
    wdata = 36'h000000000;
    be = 4'h0;
  end

  // One access per port clock rise, request held 2+GAP system clocks past the clock fall
  task automatic access(input logic w, input logic [13:0] a, input logic [35:0] d,
                        input logic [3:0] b, input logic e);
    @(posedge sys_clk);
    wr_en <= w;
    loc <= a;
    wdata <= d;
    be <= b;
    in_en <= e;
    @(posedge sys_clk);
    pclk <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pclk <= 1'b0;
    repeat (2 + GAP) @(posedge sys_clk);
    in_en <= 1'b0;
    loc <= ~a;
    wdata <= ~d;
    @(negedge sys_clk);
  endtask

  // Output register enable level
  task automatic hold_out(input logic v);
    @(posedge sys_clk);
    out_en <= v;
  endtask

  // Register reset pulse
  task automatic reg_reset();
    @(posedge sys_clk);
    reg_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reg_rst <= 1'b0;
    @(negedge sys_clk);
  endtask
endmodule

// File: tb_bsram_block.sv
// Self-checking bench: APB configuration plus two fabric users on the ports
// Assumes the image load starts once status reports ready after reset release
`timescale 1ns/1ps
module tb_bsram_block;
  logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, block_select, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        a_clk, a_ie, a_oe, a_we, a_rr, b_clk, b_ie, b_oe, b_we, b_rr;
  logic [13:0] a_loc, b_loc;
  logic [35:0] a_wd, b_wd, a_rd, b_rd, d, prev;
  logic [3:0]  a_be, b_be;
  int          miscompares, samples_checked, i, n;
  int          wid[9] = '{1, 2, 4, 8, 16, 32, 9, 18, 36};

  bsram_block bsram_block_inst (.SYS_CLK(sys_clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .BLOCK_SELECT(block_select), .PORT_A_CLOCK(a_clk),
    .PORT_A_INPUT_CLOCK_ENABLE(a_ie), .PORT_A_OUTPUT_CLOCK_ENABLE(a_oe),
    .PORT_A_WRITE_ENABLE(a_we), .PORT_A_REGISTER_RESET(a_rr), .PORT_A_LOCATION(a_loc),
    .PORT_A_WRITE_DATA(a_wd), .PORT_A_BYTE_ENABLE(a_be), .PORT_A_READ_DATA(a_rd),
    .PORT_B_CLOCK(b_clk), .PORT_B_INPUT_CLOCK_ENABLE(b_ie),
    .PORT_B_OUTPUT_CLOCK_ENABLE(b_oe), .PORT_B_WRITE_ENABLE(b_we),
    .PORT_B_REGISTER_RESET(b_rr), .PORT_B_LOCATION(b_loc), .PORT_B_WRITE_DATA(b_wd),
    .PORT_B_BYTE_ENABLE(b_be), .PORT_B_READ_DATA(b_rd));

  bsram_user #(.GAP(0)) side_a (.sys_clk(sys_clk), .pclk(a_clk), .in_en(a_ie),
    .out_en(a_oe), .wr_en(a_we), .reg_rst(a_rr), .loc(a_loc), .wdata(a_wd), .be(a_be));
  bsram_user #(.GAP(3)) side_b (.sys_clk(sys_clk), .pclk(b_clk), .in_en(b_ie),
    .out_en(b_oe), .wr_en(b_we), .reg_rst(b_rr), .loc(b_loc), .wdata(b_wd), .be(b_be));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checked=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dd);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
  endtask

  function automatic logic [31:0] cfg(input logic [1:0] m, input logic p,
                                      input logic [1:0] w, input logic [3:0] wa);
    return {18'h0, wa, wa, 1'b0, w, p, m};
  endfunction

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    block_select = 1'b1;
    miscompares = 0;
    samples_checked = 0;
    prev = 36'h000000000;
    repeat (5) @(posedge sys_clk);
    chk(a_rd, 36'h0);
    chk(b_rd, 36'h0);
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk(a_rd, 36'h0);
    apb(1'b0, bsram_pkg::CFG_OFS, 32'h0);
    chk(q, 36'(bsram_pkg::CFG_RESET));
    n = 0;
    do begin
      apb(1'b0, bsram_pkg::STAT_OFS, 32'h0);
      n++;
    end while (q[bsram_pkg::STAT_READY_BIT] !== 1'b1 && n < 300);
    chk(q[bsram_pkg::STAT_READY_BIT], 36'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk(e, 36'h1);
    chk(q, 36'h0);
    done("reset");
    apb(1'b1, bsram_pkg::IMG_ADDR_OFS, 32'h5);
    apb(1'b1, bsram_pkg::IMG_HI_OFS, 32'hA);
    apb(1'b1, bsram_pkg::IMG_LO_OFS, 32'h12345678);
    apb(1'b1, bsram_pkg::IMG_LO_OFS, 32'hFF);
    apb(1'b1, bsram_pkg::CFG_OFS, cfg(2'd3, 1'b0, 2'd0, 4'h8));
    side_a.access(1'b0, 14'h6, 36'h0, 4'h0, 1'b1);
    chk(a_rd, 36'hA000000FF);
    side_a.access(1'b1, 14'h5, 36'h0, 4'hF, 1'b1);
    side_a.access(1'b0, 14'h5, 36'h0, 4'h0, 1'b1);
    chk(a_rd, 36'hA12345678);
    side_a.reg_reset();
    chk(a_rd, 36'h0);
    side_a.access(1'b0, 14'h5, 36'h0, 4'h0, 1'b1);
    chk(a_rd, 36'hA12345678);
    done("rom");
    for (i = 0; i < 9; i++) begin
      apb(1'b1, bsram_pkg::CFG_OFS, cfg(2'd0, 1'b0, 2'd0, i[3:0]));
      d = 36'h9A5A5A5A5 & ((36'h1 << wid[i]) - 36'h1);
      side_a.access(1'b1, 14'h1, 36'h9A5A5A5A5, 4'hF, 1'b1);
      side_a.access(1'b0, 14'h1, 36'h0, 4'h0, 1'b1);
      chk(a_rd, d);
    end
    side_a.access(1'b1, 14'h1, 36'h0, 4'hF, 1'b0);
    side_a.access(1'b0, 14'h1, 36'h0, 4'h0, 1'b1);
    chk(a_rd, 36'h9A5A5A5A5);
    done("shapes");
    for (i = 0; i < 3; i++) begin
      apb(1'b1, bsram_pkg::CFG_OFS, cfg(2'd0, 1'b0, i[1:0], 4'h8));
      side_a.access(1'b0, 14'h3, 36'h0, 4'h0, 1'b1);
      d = 36'hC00000000 + 36'(i + 1);
      side_a.access(1'b1, 14'h2, d, 4'hF, 1'b1);
      chk(a_rd, (i == 0) ? 36'h0 : ((i == 1) ? d : prev));
      prev = d;
    end
    done("write modes");
    apb(1'b1, bsram_pkg::CFG_OFS, cfg(2'd0, 1'b0, 2'd0, 4'h5));
    side_a.access(1'b1, 14'h7, 36'hFFFFFFFF, 4'hF, 1'b1);
    side_a.access(1'b1, 14'h7, 36'h0, 4'h5, 1'b1);
    side_a.access(1'b0, 14'h7, 36'h0, 4'h0, 1'b1);
    chk(a_rd, 36'hFF00FF00);
    done("byte lanes");
    apb(1'b1, bsram_pkg::CFG_OFS, cfg(2'd0, 1'b1, 2'd0, 4'h8));
    side_a.access(1'b0, 14'h5, 36'h0, 4'h0, 1'b1);
    side_a.access(1'b0, 14'h6, 36'h0, 4'h0, 1'b1);
    chk(a_rd, 36'hA12345678);
    side_a.hold_out(1'b0);
    side_a.access(1'b0, 14'h5, 36'h0, 4'h0, 1'b1);
    chk(a_rd, 36'hA12345678);
    side_a.hold_out(1'b1);
    done("pipeline");
    apb(1'b1, bsram_pkg::CFG_OFS, cfg(2'd1, 1'b0, 2'd0, 4'h4));
    // Distinct locations on the two ports
    fork
      side_a.access(1'b1, 14'hA, 36'h1234, 4'h3, 1'b1);
      side_b.access(1'b1, 14'hB, 36'h5678, 4'h3, 1'b1);
    join
    fork
      side_a.access(1'b0, 14'hB, 36'h0, 4'h0, 1'b1);
      side_b.access(1'b0, 14'hA, 36'h0, 4'h0, 1'b1);
    join
    chk(a_rd, 36'h5678);
    chk(b_rd, 36'h1234);
    side_b.reg_reset();
    chk(b_rd, 36'h0);
    done("dual");
    apb(1'b1, bsram_pkg::CFG_OFS, cfg(2'd2, 1'b0, 2'd0, 4'h4));
    side_b.access(1'b1, 14'hA, 36'hFFFF, 4'h3, 1'b1);
    fork
      side_a.access(1'b1, 14'hC, 36'hAB, 4'h3, 1'b1);
      side_b.access(1'b0, 14'hA, 36'h0, 4'h0, 1'b1);
    join
    chk(b_rd, 36'h1234);
    side_b.access(1'b0, 14'hC, 36'h0, 4'h0, 1'b1);
    chk(b_rd, 36'hAB);
    done("semi");
    wrap_up();
  end
endmodule
